/* core/asrc_ctrl.sv */
// Host controller for an asynchronous 256K x 4 static memory
// Summary of operation
// - Write-enable held high throughout every read.
// - Read cycle lasts at least fifteen nanoseconds.
// - Continuous select reads follow each address.
// - Write only with select, write-enable low, 12ns.
// - Write cycle lasts at least fifteen nanoseconds.
// - Address stable before and through write-enable; the controller sets it on the same edge that drops write-enable.
// - Data valid 7ns before write end.
`timescale 1ns/1ps
module asrc_ctrl (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire asrc_pkg::asrc_req_t         req,
  output logic                             reqReady,
  output logic                             rdValid,
  output logic [asrc_pkg::DATA_W-1:0]      rdData,
  output logic                             memSelN,
  output logic                             memOeN,
  output logic                             memWeN,
  output logic [asrc_pkg::ADDR_W-1:0]      memAddr,
  output logic [asrc_pkg::DATA_W-1:0]      memDqOut,
  output logic                             memDqOe,
  input  wire logic [asrc_pkg::DATA_W-1:0] memDqIn
);
  typedef struct packed {
    asrc_pkg::asrc_state_t       state;
    logic [3:0]                  cnt;
    asrc_pkg::asrc_pins_t        pins;
    logic                        ready;
    logic                        rdValid;
    logic [asrc_pkg::DATA_W-1:0] rdData;
  } asrc_ctrl_st_t;

  asrc_ctrl_st_t               s_r;
  asrc_ctrl_st_t               s_nxt;
  logic [asrc_pkg::DATA_W-1:0] dqSync;

  // Sample pins only after two flops; read wait covers the extra latency
  asrc_sync u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     (memDqIn),
    .dout    (dqSync)
  );

  function automatic logic cnt_done(input logic [3:0] c, input int lim);
    return int'(c) >= lim - 1;
  endfunction : cnt_done

  // Deselect and float, keeping address and data where they are
  function automatic asrc_pkg::asrc_pins_t release_pins(input asrc_pkg::asrc_pins_t p);
    asrc_pkg::asrc_pins_t r;
    r      = p;
    r.selN = 1'b1;
    r.oeN  = 1'b1;
    r.weN  = 1'b1;
    r.dqOe = 1'b0;
    return r;
  endfunction : release_pins

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdValid = 1'b0;
    unique case (s_r.state)
      asrc_pkg::ASRC_IDLE: begin
        s_nxt.pins  = release_pins(s_r.pins);
        s_nxt.ready = 1'b1;
        if (s_r.ready && req.valid) begin
          s_nxt.ready     = 1'b0;
          s_nxt.cnt       = asrc_pkg::CNT_RESET;
          s_nxt.pins.addr = req.addr;
          s_nxt.pins.selN = 1'b0;
          if (req.write) begin
            // Address and data set up with strobe; own data only after float time
            s_nxt.pins.weN  = 1'b0;
            s_nxt.pins.dqOut = req.wdata;
            s_nxt.state     = asrc_pkg::ASRC_WRPUL;
          end else begin
            // Select and output enable stay low for the whole access
            s_nxt.pins.oeN = 1'b0;
            s_nxt.state    = asrc_pkg::ASRC_RDACC;
          end
        end
      end
      asrc_pkg::ASRC_RDACC: begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        // Access time plus synchroniser depth
        if (cnt_done(s_r.cnt, asrc_pkg::RD_HOLD_CYC)) begin
          s_nxt.rdData  = dqSync;
          s_nxt.rdValid = 1'b1;
          s_nxt.pins    = release_pins(s_r.pins);
          s_nxt.cnt   = asrc_pkg::CNT_RESET;
          s_nxt.state = asrc_pkg::ASRC_RDEND;
        end
      end
      asrc_pkg::ASRC_RDEND: begin
        // Let the device float before anyone drives the bus
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (cnt_done(s_r.cnt, asrc_pkg::FLOAT_CYC)) begin
          s_nxt.ready = 1'b1;
          s_nxt.state = asrc_pkg::ASRC_IDLE;
        end
      end
      asrc_pkg::ASRC_WRPUL: begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (cnt_done(s_r.cnt, asrc_pkg::FLOAT_CYC)) begin
          s_nxt.pins.dqOe = 1'b1;
        end
        // Pulse covers float wait, data setup and pulse width
        if (cnt_done(s_r.cnt, asrc_pkg::WR_LOW_CYC)) begin
          s_nxt.pins.weN = 1'b1;
          s_nxt.cnt   = asrc_pkg::CNT_RESET;
          s_nxt.state = asrc_pkg::ASRC_WREND;
        end
      end
      asrc_pkg::ASRC_WREND: begin
        // Address and data held one cycle past the write-enable rise
        s_nxt.pins      = release_pins(s_r.pins);
        s_nxt.ready     = 1'b1;
        s_nxt.state     = asrc_pkg::ASRC_IDLE;
      end
      default: begin
        s_nxt.state = asrc_pkg::ASRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r.state <= asrc_pkg::ASRC_IDLE;
      s_r.cnt   <= asrc_pkg::CNT_RESET;
      s_r.pins  <= '{selN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: 18'h00000, dqOut: 4'h0, dqOe: 1'b0};
      s_r.ready <= 1'b0;
      s_r.rdValid <= 1'b0;
      s_r.rdData  <= 4'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reqReady = s_r.ready;
  assign rdValid  = s_r.rdValid;
  assign rdData   = s_r.rdData;
  assign memSelN  = s_r.pins.selN;
  assign memOeN   = s_r.pins.oeN;
  assign memWeN   = s_r.pins.weN;
  assign memAddr  = s_r.pins.addr;
  assign memDqOut = s_r.pins.dqOut;
  assign memDqOe  = s_r.pins.dqOe;
endmodule : asrc_ctrl

/* core/asrc_pkg.sv */
// Package: timing constants, states and request carriers for the memory controller
package asrc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 4;
  localparam int CLK_PERIOD_NS = 100;
  // Fastest grade figures in ns
  localparam int CYCLE_TIME_MIN_NS       = 15;
  localparam int ADDRESS_ACCESS_MAX_NS   = 15;
  localparam int SELECT_ACCESS_MAX_NS    = 15;
  localparam int OUTPUT_ON_ACCESS_MAX_NS = 6;
  localparam int OE_TO_FLOAT_MAX_NS      = 6;
  localparam int WRITE_PULSE_MIN_NS      = 12;
  localparam int ADDR_TO_WRITE_END_NS    = 12;
  localparam int DATA_TO_WRITE_END_NS    = 7;
  localparam int STROBE_TO_FLOAT_MAX_NS  = 6;
  // Least times rounded up, one cycle at least
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc
  localparam int RD_WAIT_CYC = ceil_cyc(ADDRESS_ACCESS_MAX_NS > SELECT_ACCESS_MAX_NS ?
                                        ADDRESS_ACCESS_MAX_NS : SELECT_ACCESS_MAX_NS);
  localparam int WR_PULSE_CYC = ceil_cyc(WRITE_PULSE_MIN_NS > ADDR_TO_WRITE_END_NS ?
                                         WRITE_PULSE_MIN_NS : ADDR_TO_WRITE_END_NS);
  localparam int FLOAT_CYC = ceil_cyc(OE_TO_FLOAT_MAX_NS > STROBE_TO_FLOAT_MAX_NS ?
                                      OE_TO_FLOAT_MAX_NS : STROBE_TO_FLOAT_MAX_NS);
  localparam int CYCLE_CYC = ceil_cyc(CYCLE_TIME_MIN_NS);
  localparam int SYNC_STAGES = 2;
  localparam int DATA_SETUP_CYC = ceil_cyc(DATA_TO_WRITE_END_NS);
  // Read select window: access plus synchroniser, never below one cycle time
  localparam int RD_HOLD_CYC = (RD_WAIT_CYC + SYNC_STAGES > CYCLE_CYC) ?
                               RD_WAIT_CYC + SYNC_STAGES : CYCLE_CYC;
  // Strobe low time: pulse width, or float wait plus data setup, or cycle time
  localparam int WR_LOW_BASE = (WR_PULSE_CYC > FLOAT_CYC + DATA_SETUP_CYC) ?
                               WR_PULSE_CYC : FLOAT_CYC + DATA_SETUP_CYC;
  localparam int WR_LOW_CYC = (WR_LOW_BASE > CYCLE_CYC) ? WR_LOW_BASE : CYCLE_CYC;
  localparam logic [3:0] CNT_RESET = 4'h0;

  typedef enum logic [4:0] {
    ASRC_IDLE  = 5'h01,
    ASRC_RDACC = 5'h02,
    ASRC_RDEND = 5'h04,
    ASRC_WRPUL = 5'h08,
    ASRC_WREND = 5'h10
  } asrc_state_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic              selN;
    logic              oeN;
    logic              weN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
    logic              dqOe;
  } asrc_pins_t;
endpackage : asrc_pkg

/* core/asrc_sync.sv */
// Two-stage synchroniser for the data pins
`timescale 1ns/1ps
module asrc_sync (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [asrc_pkg::DATA_W-1:0]   din,
  output logic      [asrc_pkg::DATA_W-1:0]   dout
);
  typedef struct packed {
    logic [asrc_pkg::DATA_W-1:0] meta;
    logic [asrc_pkg::DATA_W-1:0] held;
  } asrc_sync_st_t;

  asrc_sync_st_t s_r;
  asrc_sync_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = din;
    s_nxt.held = s_r.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Only the second stage leaves the module
  assign dout = s_r.held;
endmodule : asrc_sync

/* verification/asrc_ctrl_monitor.sv */
// Checker for the controller pin sequencing
`timescale 1ns/1ps
module asrc_ctrl_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        reqReady,
  input wire logic        rdValid,
  input wire logic        memSelN,
  input wire logic        memOeN,
  input wire logic        memWeN,
  input wire logic [17:0] memAddr,
  input wire logic [3:0]  memDqOut,
  input wire logic        memDqOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wrLow;
    !memWeN && !memSelN;
  endsequence
  property p_wrPulse; $fell(memWeN) |-> s_wrLow ##1 s_wrLow ##1 (memWeN && !memSelN); endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write pulse short");
  property p_wrCycle; $fell(memWeN) |-> ##3 (memSelN && reqReady); endproperty
  a_wrCycle: assert property (p_wrCycle) else $error("write cycle length");
  property p_wrAddr; !memWeN |=> $stable(memAddr); endproperty
  a_wrAddr: assert property (p_wrAddr) else $error("address moved in write");
  property p_wrData; $rose(memWeN) |-> memDqOe && $stable(memDqOut); endproperty
  a_wrData: assert property (p_wrData) else $error("write data not held");
  property p_wrFloat; $fell(memWeN) |-> !memDqOe ##1 memDqOe; endproperty
  a_wrFloat: assert property (p_wrFloat) else $error("drive before float");
  property p_rdWe; !memOeN |-> memWeN && !memDqOe; endproperty
  a_rdWe: assert property (p_rdWe) else $error("write strobe in read");
  property p_rdHold; $fell(memOeN) |=> ($stable(memAddr) && !memOeN)[*2] ##1 (memOeN && memSelN); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read cycle length");
  property p_rdValid; $fell(memOeN) |-> !rdValid ##3 rdValid; endproperty
  a_rdValid: assert property (p_rdValid) else $error("read answer late");
  property p_idle; reqReady |-> memSelN && memOeN && memWeN && !memDqOe; endproperty
  a_idle: assert property (p_idle) else $error("pins busy while ready");
  property p_rdSel; !memOeN |-> !memSelN; endproperty
  a_rdSel: assert property (p_rdSel) else $error("output enable without select");
endmodule : asrc_ctrl_monitor

/* verification/asrc_sram_model.sv */
// Behavioural asynchronous static memory, 256K x 4
`timescale 1ns/1ps
module asrc_sram_model (
  input wire logic        selN,
  input wire logic        oeN,
  input wire logic        weN,
  input wire logic [17:0] addr,
  input wire logic [3:0]  dqIn,
  output logic     [3:0]  dqOut,
  output logic            dqOe
);
  logic [3:0] memArr [0:262143];
  logic [3:0] lastOut = 4'h0;
  wire        rdEn = !selN && !oeN && weN;
  wire  [3:0] rdWord;
  assign #15 rdWord = memArr[addr];
  always @(rdEn) begin
    if (rdEn) dqOe <= #5 1'b1;
    else dqOe <= #3 1'b0;
  end
  always @(rdWord or dqOe) if (dqOe) lastOut = rdWord;
  // Released pins show the inverse of the last word
  assign dqOut = dqOe ? rdWord : ~lastOut;
  always @(posedge weN) if (!selN) memArr[addr] <= dqIn;
endmodule : asrc_sram_model

/* verification/asrc_ctrl_tb.sv */
// Self-checking bench for the memory controller
`timescale 1ns/1ps
module asrc_ctrl_tb;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  asrc_pkg::asrc_req_t req = '0;
  logic                reqReady, rdValid, memSelN, memOeN, memWeN, memDqOe, drvOe;
  logic [3:0]          rdData, memDqOut, drvData;
  logic [17:0]         memAddr;
  wire  [3:0]          dqWire = memDqOe ? memDqOut : drvData;
  int                  err_total = 0;
  int                  checks = 0;
  localparam logic [17:0] AT [4] = '{18'h00000, 18'h3FFFF, 18'h15555, 18'h2AAAA};
  localparam logic [3:0]  DT [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
  asrc_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .req(req), .reqReady(reqReady), .rdValid(rdValid),
    .rdData(rdData), .memSelN(memSelN), .memOeN(memOeN), .memWeN(memWeN), .memAddr(memAddr),
    .memDqOut(memDqOut), .memDqOe(memDqOe), .memDqIn(dqWire));
  asrc_sram_model mem_u (.selN(memSelN), .oeN(memOeN), .weN(memWeN), .addr(memAddr), .dqIn(dqWire),
    .dqOut(drvData), .dqOe(drvOe));
  initial forever #50 sys_clk = ~sys_clk;
  always @(memDqOe or drvOe) begin
    if (memDqOe === 1'b1 && drvOe === 1'b1) begin
      err_total++;
      $display("CHECK FAILED bus contention expected 0 seen 1");
    end
  end
  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic issue(input logic wr, input logic [17:0] a, input logic [3:0] d);
    req = '{1'b1, wr, a, d};
    for (int n = 0; reqReady !== 1'b1; n++) begin
      if (n == 20) begin err_total++; summarize(); end
      @(posedge sys_clk) #1;
    end
    @(posedge sys_clk) #1;
    req.valid = 1'b0;
    // One idle edge keeps valid low between two requests
    @(posedge sys_clk) #1;
  endtask : issue
  // Reset in the middle of a write pulse, then a clean restart
  task automatic rst_mid;
    issue(1'b1, 18'h00001, 4'h6);
    rst = 1'b1;
    @(posedge sys_clk) #1;
    check("reset pins", 18'h7, {15'h0, memSelN, memOeN, memWeN});
    check("reset drive", 18'h0, {16'h0, memDqOe, reqReady});
    @(posedge sys_clk) #1;
    rst = 1'b0;
    @(posedge sys_clk) #1;
    check("ready after reset", 18'h1, {17'h0, reqReady});
  endtask : rst_mid
  // Read with an optional write attempted while busy
  task automatic rd(input logic [17:0] a, input logic [3:0] exp, input logic poke);
    int n;
    n = 1;
    issue(1'b0, a, 4'h0);
    if (poke) begin
      check("busy ready", 18'h0, {17'h0, reqReady});
      req = '{1'b1, 1'b1, a, ~exp};
      @(posedge sys_clk) #1;
      req.valid = 1'b0;
      n = 2;
    end
    for (; rdValid !== 1'b1; n++) begin
      if (n == 20) begin err_total++; summarize(); end
      @(posedge sys_clk) #1;
    end
    check("read latency", 18'(asrc_pkg::RD_HOLD_CYC), n[17:0]);
    check("read data", {14'h0, exp}, {14'h0, rdData});
  endtask : rd
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    @(posedge sys_clk) #1;
    check("idle pins", 18'h7, {15'h0, memSelN, memOeN, memWeN});
    check("idle drive", 18'h0, {17'h0, memDqOe});
    for (int i = 0; i < 4; i++) issue(1'b1, AT[i], DT[i]);
    for (int i = 3; i >= 0; i--) rd(AT[i], DT[i], 1'b0);
    rd(AT[0], DT[0], 1'b1);
    rd(AT[0], DT[0], 1'b0);
    rst_mid();
    rd(AT[1], DT[1], 1'b0);
    summarize();
  end
endmodule : asrc_ctrl_tb
bind asrc_ctrl asrc_ctrl_monitor mon_u (.sys_clk(sys_clk), .rst(rst), .reqReady(reqReady), .rdValid(rdValid),
  .memSelN(memSelN), .memOeN(memOeN), .memWeN(memWeN), .memAddr(memAddr), .memDqOut(memDqOut),
  .memDqOe(memDqOe));
